// ==== shared/rds_pkg.sv ====
// Purpose: Constants for the roller drive status register bank
// Assumes: APB word access, register index times four is the byte address
// Notes: All measured registers are 16 bits wide, read only
package rds_pkg;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   // ----------------------------------------
   // Register indices
   // ----------------------------------------
   localparam logic [11:0] IDX_SENSOR_ATTACH = 12'h6A6;
   localparam logic [11:0] IDX_SUPPLY_VOLT = 12'h6A7;
   localparam logic [11:0] IDX_LEFT_CURRENT = 12'h6A8;
   localparam logic [11:0] IDX_LEFT_FREQ = 12'h6A9;
   localparam logic [11:0] IDX_LEFT_TEMP = 12'h6AA;
   localparam logic [11:0] IDX_LEFT_STATUS = 12'h6AB;
   localparam logic [11:0] IDX_RIGHT_CURRENT = 12'h6AC;
   localparam logic [11:0] IDX_RIGHT_FREQ = 12'h6AD;
   localparam logic [11:0] IDX_RIGHT_TEMP = 12'h6AE;
   localparam logic [11:0] IDX_RIGHT_STATUS = 12'h6AF;
   localparam logic [11:0] IDX_INT_STATUS = 12'h6B0;
   localparam logic [11:0] IDX_INT_MASK = 12'h6B1;
   localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;
   // ----------------------------------------
   // Field layout
   // ----------------------------------------
   localparam logic [15:0] VOLT_MAX_MV = 16'h88B8;
   localparam int ATT_RIGHT_BIT = 0;
   localparam int ATT_LEFT_BIT = 1;
   localparam int TEMP_MOTOR_LSB = 8;
   localparam int TEMP_BOARD_LSB = 0;
   localparam int MS_STATE_LSB = 0;
   localparam int MS_DIGITAL_BIT = 2;
   localparam int MS_BOARD_HOT_BIT = 5;
   localparam int MS_OVER_V_BIT = 6;
   localparam int MS_LOW_V_BIT = 7;
   localparam int MS_FAULT_LSB = 8;
   localparam logic [7:0] FAULT_ACTIVE_MASK = 8'h7F;
   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   localparam int INT_W = 4;
   localparam int EV_LEFT_FAULT = 0;
   localparam int EV_RIGHT_FAULT = 1;
   localparam int EV_ATTACH_CHANGE = 2;
   localparam int EV_SUPPLY_FAULT = 3;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [INT_W-1:0] INT_RESET = 4'h0;
endpackage

// ==== rtl/rds_status_inputs.sv ====
// Contract
// - Supply voltage in millivolts, clamped to 35000
// - Temperature: motor high byte, board low byte
// - Frequency register holds live hertz
// - Attach bit0 right port, bit1 left port
// - Status bits 0-1 state, bit 2 digital
// - Left word: board hot, over-voltage, low voltage
// - Bits 8-10: overheat, max torque, short
// - Bits 11-13: no motor, overload, stall
// - Bit 14 hall fault, bit 15 unused; the code still copies fault input bit 7 into bit 15
// - Right word bits 3-5 reserved zero
// - Status registers read only, writes ignored
// - Every measurement register is sixteen bits wide, interrupt status and mask four
//
// Purpose: APB status bank of a two-zone roller drive, read only except interrupt status and mask
// Assumes: Measurement inputs synchronous to clk
// Notes: Interrupt status is write-one-to-clear, set wins
`timescale 1ns/1ps
`default_nettype none
module rds_status_inputs #(
   parameter int TEMP_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rds_pkg::ADDR_W-1:0] paddr,
   input wire logic [rds_pkg::DATA_W-1:0] pwdata,
   output logic [rds_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic rightAttached,
   input wire logic leftAttached,
   input wire logic [rds_pkg::REG_W-1:0] supplyMv,
   input wire logic [rds_pkg::REG_W-1:0] leftCurrentMa,
   input wire logic [rds_pkg::REG_W-1:0] leftFreqHz,
   input wire logic [TEMP_W-1:0] leftMotorTempC,
   input wire logic [TEMP_W-1:0] leftBoardTempC,
   input wire logic [1:0] leftMotorState,
   input wire logic leftDigitalMode,
   input wire logic [7:0] leftFaults,
   input wire logic [rds_pkg::REG_W-1:0] rightCurrentMa,
   input wire logic [rds_pkg::REG_W-1:0] rightFreqHz,
   input wire logic [TEMP_W-1:0] rightMotorTempC,
   input wire logic [TEMP_W-1:0] rightBoardTempC,
   input wire logic [1:0] rightMotorState,
   input wire logic rightDigitalMode,
   input wire logic [7:0] rightFaults,
   input wire logic boardOverheat,
   input wire logic overVoltage,
   input wire logic lowVoltage
);
   import rds_pkg::*;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic hitIdx(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
      hitIdx = (a[ADDR_W-1:2] == idx) && (a[1:0] == ADDR_LSB_ZERO);
   endfunction

   function automatic logic [REG_W-1:0] packStatus(input logic [1:0] st, input logic dig,
         input logic brdHot, input logic overV, input logic lowV, input logic [7:0] flt);
      logic [REG_W-1:0] w;
      w = REG_RESET;
      w[MS_STATE_LSB +: 2] = st;
      w[MS_DIGITAL_BIT] = dig;
      w[MS_BOARD_HOT_BIT] = brdHot;
      w[MS_OVER_V_BIT] = overV;
      w[MS_LOW_V_BIT] = lowV;
      w[MS_FAULT_LSB +: 8] = flt;
      packStatus = w;
   endfunction

   function automatic logic [REG_W-1:0] packTemp(input logic [TEMP_W-1:0] motorC,
         input logic [TEMP_W-1:0] boardC);
      logic [REG_W-1:0] t;
      t = REG_RESET;
      t[TEMP_MOTOR_LSB +: 8] = motorC[7:0];
      t[TEMP_BOARD_LSB +: 8] = boardC[7:0];
      packTemp = t;
   endfunction

   // ----------------------------------------
   // Live measurement registers
   // ----------------------------------------
   logic [REG_W-1:0] attach_r, attach_nxt;
   logic [REG_W-1:0] volt_r, volt_nxt;
   logic [REG_W-1:0] lCur_r, lCur_nxt;
   logic [REG_W-1:0] lFreq_r, lFreq_nxt;
   logic [REG_W-1:0] lTemp_r, lTemp_nxt;
   logic [REG_W-1:0] lStat_r, lStat_nxt;
   logic [REG_W-1:0] rCur_r, rCur_nxt;
   logic [REG_W-1:0] rFreq_r, rFreq_nxt;
   logic [REG_W-1:0] rTemp_r, rTemp_nxt;
   logic [REG_W-1:0] rStat_r, rStat_nxt;

   always_comb begin
      attach_nxt = REG_RESET;
      attach_nxt[ATT_RIGHT_BIT] = rightAttached;
      attach_nxt[ATT_LEFT_BIT] = leftAttached;
      volt_nxt = (supplyMv > VOLT_MAX_MV) ? VOLT_MAX_MV : supplyMv;
      lCur_nxt = leftCurrentMa;
      lFreq_nxt = leftFreqHz;
      rCur_nxt = rightCurrentMa;
      rFreq_nxt = rightFreqHz;
      lTemp_nxt = packTemp(leftMotorTempC, leftBoardTempC);
      rTemp_nxt = packTemp(rightMotorTempC, rightBoardTempC);
      lStat_nxt = packStatus(leftMotorState, leftDigitalMode, boardOverheat, overVoltage,
                             lowVoltage, leftFaults);
      // Right word keeps bits 3 to 5 clear
      rStat_nxt = packStatus(rightMotorState, rightDigitalMode, 1'b0, overVoltage,
                             lowVoltage, rightFaults);
   end

   // Refreshed on every edge, never latched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         attach_r <= REG_RESET;
         volt_r <= REG_RESET;
         lCur_r <= REG_RESET;
         lFreq_r <= REG_RESET;
         lTemp_r <= REG_RESET;
         lStat_r <= REG_RESET;
         rCur_r <= REG_RESET;
         rFreq_r <= REG_RESET;
         rTemp_r <= REG_RESET;
         rStat_r <= REG_RESET;
      end else begin
         attach_r <= attach_nxt;
         volt_r <= volt_nxt;
         lCur_r <= lCur_nxt;
         lFreq_r <= lFreq_nxt;
         lTemp_r <= lTemp_nxt;
         lStat_r <= lStat_nxt;
         rCur_r <= rCur_nxt;
         rFreq_r <= rFreq_nxt;
         rTemp_r <= rTemp_nxt;
         rStat_r <= rStat_nxt;
      end
   end

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   logic [INT_W-1:0] intStat_r, intStat_nxt;
   logic [INT_W-1:0] intMask_r, intMask_nxt;
   logic [INT_W-1:0] events;
   logic setupPhase;
   logic accessPhase;
   logic wrStat;
   logic wrMask;

   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign wrStat = accessPhase && pwrite && hitIdx(paddr, IDX_INT_STATUS);
   assign wrMask = accessPhase && pwrite && hitIdx(paddr, IDX_INT_MASK);

   always_comb begin
      events = INT_RESET;
      events[EV_LEFT_FAULT] = |(lStat_nxt[MS_FAULT_LSB +: 8] & ~lStat_r[MS_FAULT_LSB +: 8]
                                & FAULT_ACTIVE_MASK);
      events[EV_RIGHT_FAULT] = |(rStat_nxt[MS_FAULT_LSB +: 8] & ~rStat_r[MS_FAULT_LSB +: 8]
                                 & FAULT_ACTIVE_MASK);
      events[EV_ATTACH_CHANGE] = attach_nxt != attach_r;
      events[EV_SUPPLY_FAULT] = (overVoltage && !lStat_r[MS_OVER_V_BIT])
                                || (lowVoltage && !lStat_r[MS_LOW_V_BIT]);
      intStat_nxt = intStat_r;
      if (wrStat) begin
         intStat_nxt = intStat_r & ~pwdata[INT_W-1:0];
      end
      // Set wins over a clear in the same cycle
      intStat_nxt = intStat_nxt | events;
      intMask_nxt = wrMask ? pwdata[INT_W-1:0] : intMask_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intStat_r <= INT_RESET;
         intMask_r <= INT_RESET;
      end else begin
         intStat_r <= intStat_nxt;
         intMask_r <= intMask_nxt;
      end
   end

   assign irq = |(intStat_r & intMask_r);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic err_r, err_nxt;
   logic [REG_W-1:0] rdSel;
   logic rdHit;

   always_comb begin
      rdSel = REG_RESET;
      rdHit = 1'b1;
      if (hitIdx(paddr, IDX_SENSOR_ATTACH)) begin
         rdSel = attach_r;
      end else if (hitIdx(paddr, IDX_SUPPLY_VOLT)) begin
         rdSel = volt_r;
      end else if (hitIdx(paddr, IDX_LEFT_CURRENT)) begin
         rdSel = lCur_r;
      end else if (hitIdx(paddr, IDX_LEFT_FREQ)) begin
         rdSel = lFreq_r;
      end else if (hitIdx(paddr, IDX_LEFT_TEMP)) begin
         rdSel = lTemp_r;
      end else if (hitIdx(paddr, IDX_LEFT_STATUS)) begin
         rdSel = lStat_r;
      end else if (hitIdx(paddr, IDX_RIGHT_CURRENT)) begin
         rdSel = rCur_r;
      end else if (hitIdx(paddr, IDX_RIGHT_FREQ)) begin
         rdSel = rFreq_r;
      end else if (hitIdx(paddr, IDX_RIGHT_TEMP)) begin
         rdSel = rTemp_r;
      end else if (hitIdx(paddr, IDX_RIGHT_STATUS)) begin
         rdSel = rStat_r;
      end else if (hitIdx(paddr, IDX_INT_STATUS)) begin
         rdSel = {{(REG_W-INT_W){1'b0}}, intStat_r};
      end else if (hitIdx(paddr, IDX_INT_MASK)) begin
         rdSel = {{(REG_W-INT_W){1'b0}}, intMask_r};
      end else begin
         rdHit = 1'b0;
      end
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      // Captured in setup, presented in access
      if (setupPhase) begin
         rdata_nxt = pwrite ? {DATA_W{1'b0}} : {{(DATA_W-REG_W){1'b0}}, rdSel};
         err_nxt = !rdHit;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= {DATA_W{1'b0}};
         err_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   // Writes to measurement registers complete quietly and change nothing
   assign prdata = rdata_r;
   assign pready = accessPhase;
   assign pslverr = accessPhase && err_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence sSetupRead(logic [11:0] idx);
      psel && !penable && !pwrite && hitIdx(paddr, idx);
   endsequence

   sequence sAccess;
      psel && penable && pready;
   endsequence

   // Read data is the register content at the setup edge
   property pReadShows(logic [11:0] idx, logic [REG_W-1:0] val);
      @(posedge clk) disable iff (!rst_n)
         sSetupRead(idx) ##1 sAccess |-> prdata == {{(DATA_W-REG_W){1'b0}}, $past(val)};
   endproperty

   a_volt_clamp: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 volt_r == (($past(supplyMv) > VOLT_MAX_MV) ? VOLT_MAX_MV : $past(supplyMv)))
      else $error("supply voltage register not clamped value");

   a_temp_bytes: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 lTemp_r == {$past(leftMotorTempC[7:0]), $past(leftBoardTempC[7:0])}
      && rTemp_r == {$past(rightMotorTempC[7:0]), $past(rightBoardTempC[7:0])})
      else $error("temperature bytes misplaced");

   a_current_read: assert property (pReadShows(IDX_RIGHT_CURRENT, rCur_r))
      else $error("current read mismatch");

   a_freq_live: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 lFreq_r == $past(leftFreqHz) && rFreq_r == $past(rightFreqHz))
      else $error("frequency register stale");

   a_attach_bits: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 attach_r == {14'h0000, $past(leftAttached), $past(rightAttached)})
      else $error("sensor attach bits wrong");

   a_state_bits: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 lStat_r[2:0] == {$past(leftDigitalMode), $past(leftMotorState)}
      && rStat_r[2:0] == {$past(rightDigitalMode), $past(rightMotorState)})
      else $error("motor state bits wrong");

   a_left_supply: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 lStat_r[7:5] == {$past(lowVoltage), $past(overVoltage), $past(boardOverheat)})
      else $error("left supply flags wrong");

   a_fault_bits: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 lStat_r[15:8] == $past(leftFaults) && rStat_r[15:8] == $past(rightFaults))
      else $error("fault flags wrong");

   a_right_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      rStat_r[5:3] == 3'h0)
      else $error("right reserved bits set");

   a_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      (accessPhase && pwrite && !wrMask) |=> $stable(intMask_r) && !pslverr)
      else $error("write to read-only register took effect");

   a_word_width: assert property (@(posedge clk) disable iff (!rst_n)
      sAccess |-> prdata[DATA_W-1:REG_W] == 16'h0000)
      else $error("upper read data not zero");

   a_status_read: assert property (pReadShows(IDX_LEFT_STATUS, lStat_r))
      else $error("status read not live value");

   a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
      (wrStat && events[EV_ATTACH_CHANGE]) |=> intStat_r[EV_ATTACH_CHANGE])
      else $error("event lost on clear");

   a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
      (|(events & intMask_r) && !wrMask) |=> irq)
      else $error("interrupt level wrong");
endmodule
`default_nettype wire

// ==== test/rds_apb_master.sv ====
// Purpose: APB controller model that reads the status bank
// Assumes: Slave answers within a bounded number of cycles
// Notes: Signals change by NBA right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rds_apb_master (
   input wire logic clk,
   input wire logic pready,
   input wire logic [rds_pkg::DATA_W-1:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [rds_pkg::ADDR_W-1:0] paddr,
   output logic [rds_pkg::DATA_W-1:0] pwdata
);
   import rds_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end
   // ----------------------------------------
   // One transfer, held until pready
   // ----------------------------------------
   task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
         output logic [31:0] rd, output logic err, output logic hung);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, ADDR_LSB_ZERO};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      hung = (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the roller drive status bank
// Assumes: Inputs reach registers one clock before the setup edge
// Notes: Expected values built from field layout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rds_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdat;
   logic rightAttached, leftAttached, leftDigitalMode, rightDigitalMode;
   logic boardOverheat, overVoltage, lowVoltage, rerr, hung;
   logic [REG_W-1:0] supplyMv, leftCurrentMa, leftFreqHz, rightCurrentMa, rightFreqHz;
   logic [7:0] leftMotorTempC, leftBoardTempC, rightMotorTempC, rightBoardTempC, leftFaults, rightFaults;
   logic [1:0] leftMotorState, rightMotorState;
   logic [15:0] vIn [5] = '{16'h5BCC, 16'h88B8, 16'h88B9, 16'hFFFF, 16'h0000};
   logic [15:0] vExp [5] = '{16'h5BCC, 16'h88B8, 16'h88B8, 16'h88B8, 16'h0000};
   int failures;
   int checksDone;
   rds_status_inputs rds_status_inputs_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .rightAttached(rightAttached), .leftAttached(leftAttached), .supplyMv(supplyMv),
      .leftCurrentMa(leftCurrentMa), .leftFreqHz(leftFreqHz), .leftMotorTempC(leftMotorTempC),
      .leftBoardTempC(leftBoardTempC), .leftMotorState(leftMotorState), .leftDigitalMode(leftDigitalMode),
      .leftFaults(leftFaults), .rightCurrentMa(rightCurrentMa), .rightFreqHz(rightFreqHz),
      .rightMotorTempC(rightMotorTempC), .rightBoardTempC(rightBoardTempC), .rightMotorState(rightMotorState),
      .rightDigitalMode(rightDigitalMode), .rightFaults(rightFaults), .boardOverheat(boardOverheat),
      .overVoltage(overVoltage), .lowVoltage(lowVoltage));
   rds_apb_master rds_apb_master_i (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // ----------------------------------------
   // Clock and helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic summarize();
      if (failures == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic acc(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      rds_apb_master_i.xfer(wr, idx, wd, rdat, rerr, hung);
      if (hung === 1'b1) begin
         failures++;
         summarize();
      end
   endtask
   task automatic rdChk(input string name, input logic [11:0] idx, input logic [31:0] exp);
      acc(1'b0, idx, 32'h0);
      check(name, rdat, exp);
   endtask
   task automatic irqChk(input string name, input logic exp);
      @(negedge clk);
      check(name, {31'h0, irq}, {31'h0, exp});
      @(posedge clk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      checksDone = 0;
      rst_n = 1'b0;
      {rightAttached, leftAttached, leftDigitalMode, rightDigitalMode} = 4'h0;
      {boardOverheat, overVoltage, lowVoltage} = 3'h0;
      {supplyMv, leftCurrentMa, leftFreqHz, rightCurrentMa, rightFreqHz} = '0;
      {leftMotorTempC, leftBoardTempC, rightMotorTempC, rightBoardTempC} = '0;
      {leftFaults, rightFaults, leftMotorState, rightMotorState} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      irqChk("irq_reset", 1'b0);
      rightAttached <= 1'b1;
      rdChk("attach_right", IDX_SENSOR_ATTACH, 32'h1);
      rightAttached <= 1'b0;
      leftAttached <= 1'b1;
      rdChk("attach_left", IDX_SENSOR_ATTACH, 32'h2);
      foreach (vIn[i]) begin
         supplyMv <= vIn[i];
         rdChk("supply", IDX_SUPPLY_VOLT, {16'h0, vExp[i]});
      end
      leftCurrentMa <= 16'h076C;
      leftFreqHz <= 16'h012C;
      rightCurrentMa <= 16'hFFFF;
      rightFreqHz <= 16'h8001;
      leftMotorTempC <= 8'h3C;
      leftBoardTempC <= 8'h28;
      rightMotorTempC <= 8'hF6;
      rightBoardTempC <= 8'h01;
      rdChk("left_cur", IDX_LEFT_CURRENT, 32'h076C);
      rdChk("left_freq", IDX_LEFT_FREQ, 32'h012C);
      rdChk("right_cur", IDX_RIGHT_CURRENT, 32'hFFFF);
      rdChk("right_freq", IDX_RIGHT_FREQ, 32'h8001);
      rdChk("left_temp", IDX_LEFT_TEMP, 32'h3C28);
      rdChk("right_temp", IDX_RIGHT_TEMP, 32'hF601);
      leftCurrentMa <= 16'h0001;
      rdChk("left_cur_live", IDX_LEFT_CURRENT, 32'h0001);
      acc(1'b1, IDX_SUPPLY_VOLT, 32'h1234);
      check("ro_write_err", {31'h0, rerr}, 32'h0);
      acc(1'b1, IDX_LEFT_TEMP, 32'h0000);
      rdChk("ro_supply", IDX_SUPPLY_VOLT, 32'h0);
      rdChk("ro_temp", IDX_LEFT_TEMP, 32'h3C28);
      rdChk("unmapped_rd", 12'h6B2, 32'h0);
      check("unmapped_err", {31'h0, rerr}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         leftFaults <= 8'h01 << i;
         rightFaults <= 8'h80 >> i;
         leftMotorState <= i[1:0];
         rightMotorState <= ~i[1:0];
         leftDigitalMode <= i[0];
         rightDigitalMode <= ~i[0];
         boardOverheat <= i[0];
         overVoltage <= i[1];
         lowVoltage <= i[2];
         rdChk("left_status", IDX_LEFT_STATUS,
            {16'h0, 8'(8'h01 << i), i[2], i[1], i[0], 2'b00, i[0], i[1:0]});
         rdChk("right_status", IDX_RIGHT_STATUS,
            {16'h0, 8'(8'h80 >> i), i[2], i[1], 3'b000, ~i[0], ~i[1:0]});
      end
      leftFaults <= 8'h00;
      rightFaults <= 8'h00;
      {boardOverheat, overVoltage, lowVoltage} <= 3'h0;
      repeat (3) @(posedge clk);
      acc(1'b1, IDX_INT_STATUS, 32'hF);
      rdChk("int_cleared", IDX_INT_STATUS, 32'h0);
      leftFaults <= 8'h04;
      repeat (3) @(posedge clk);
      rdChk("int_left", IDX_INT_STATUS, 32'h1);
      irqChk("irq_masked", 1'b0);
      acc(1'b1, IDX_INT_MASK, 32'h1);
      irqChk("irq_unmasked", 1'b1);
      rdChk("mask_rd", IDX_INT_MASK, 32'h1);
      rightFaults <= 8'h40;
      leftAttached <= 1'b0;
      lowVoltage <= 1'b1;
      repeat (3) @(posedge clk);
      rdChk("int_all", IDX_INT_STATUS, 32'hF);
      acc(1'b1, IDX_INT_STATUS, 32'h1);
      irqChk("irq_w1c", 1'b0);
      rdChk("int_w1c", IDX_INT_STATUS, 32'hE);
      acc(1'b1, IDX_INT_MASK, 32'hC);
      irqChk("irq_mask_c", 1'b1);
      acc(1'b1, IDX_INT_STATUS, 32'hC);
      irqChk("irq_clear_c", 1'b0);
      rdChk("int_left_2", IDX_INT_STATUS, 32'h2);
      fork
         acc(1'b1, IDX_INT_STATUS, 32'h4);
         begin
            repeat (2) @(posedge clk);
            leftAttached <= 1'b1;
         end
      join
      rdChk("int_set_wins", IDX_INT_STATUS, 32'h6);
      irqChk("irq_set_wins", 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
